// [rtl/psbw_write_path.sv]
// Purpose: device-side write path of a ddr psram bus
// Assumes: clock 200 MHz; link_clk comes from the master
// Notes: link frame state clears while cs_n is high; hand-off registers keep their values
`timescale 1ns/1ps
`include "psbw_map.svh"
module psbw_write_path #(
   parameter int AW = 22,
   parameter int MAX_BURST_WORDS = 0,
   parameter bit WRAP_WRITES = 1'b1
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic ce,
   input wire logic link_clk,
   input wire logic cs_n,
   input wire logic [7:0] dq_in,
   input wire logic read_write_strobe_in,
   output logic read_write_strobe_out,
   output logic read_write_strobe_oe,
   input wire logic [3:0] latency_count,
   input wire logic extra_latency_req,
   input wire logic zero_lat_mem,
   input wire logic zero_lat_reg,
   input wire logic hybrid_wrap,
   input wire logic [2:0] wrap_len_log2,
   output logic wr_valid,
   output logic [AW-1:0] wr_addr,
   output logic [15:0] wr_data,
   output logic [1:0] wr_be,
   output logic wr_reg_space,
   output logic txn_valid,
   output logic txn_read,
   output logic txn_reg_space,
   output logic txn_linear,
   output logic txn_zero_lat,
   output logic txn_extra_lat,
   output logic burst_discard,
   output logic frame_active
);
   import psbw_pkg::*;

   // frozen configuration, system side
   logic [3:0] cfg_lat;
   logic cfg_zl_mem;
   logic cfg_zl_reg;
   logic cfg_hybrid;
   logic [2:0] cfg_wlen;
   logic strobe_level;

   // link side: rising-edge captures
   logic [7:0] dq_rise;
   logic strobe_rise;

   // link side: frame state
   psbw_phase_t phase;
   logic [1:0] ca_cyc;
   logic [31:0] ca_sr;
   logic ext_seen;
   logic [4:0] lat_left;
   logic txn_zl;
   logic txn_reg;
   logic [15:0] word_cnt;
   logic ca_drive;

   // link side: decode of the completing word
   logic [47:0] ca_now;
   logic [31:0] ca_addr;
   logic dec_write;
   logic dec_reg;
   logic dec_lin;
   logic dec_zl;
   logic [3:0] lat_base;
   logic [4:0] lat_total;
   logic ca_done;
   logic limit_hit;
   logic accept;

   // link side: words held for the system domain
   logic [AW-1:0] hold_addr;
   logic [15:0] hold_data;
   logic [1:0] hold_be;
   logic hold_reg;
   logic hold_read;
   logic hold_txn_reg;
   logic hold_lin;
   logic hold_zl;
   logic hold_ext;
   logic tog_word;
   logic tog_txn;
   logic tog_drop;

   // system side: synchronisers and edge detect
   logic [3:0] sync_s1;
   logic [3:0] sync_s2;
   logic [2:0] tog_seen;
   logic word_evt;
   logic txn_evt;
   logic drop_evt;

   psbw_burst_if #(.AW(AW)) burst ();

   psbw_addr_seq #(.AW(AW)) u_seq (
      .link_clk(link_clk),
      .frame_rst(cs_n),
      .bus(burst)
   );

   // ---- system domain ----

   // cs_n and event toggles, two flops each
   always_ff @(posedge clock) begin
      if (!rstn) begin
         sync_s1 <= `PSBW_SYNC_RST;
         sync_s2 <= `PSBW_SYNC_RST;
      end else if (ce) begin
         sync_s1 <= {tog_drop, tog_txn, tog_word, cs_n};
         sync_s2 <= sync_s1;
      end
   end

   // last toggle values already handled
   always_ff @(posedge clock) begin
      if (!rstn) begin
         tog_seen <= 3'h0;
      end else if (ce) begin
         tog_seen <= sync_s2[3:1];
      end
   end

   assign word_evt = sync_s2[1] ^ tog_seen[0];
   assign txn_evt = sync_s2[2] ^ tog_seen[1];
   assign drop_evt = sync_s2[3] ^ tog_seen[2];

   // frame indicator
   always_ff @(posedge clock) begin
      if (!rstn) begin
         frame_active <= 1'b0;
      end else if (ce) begin
         frame_active <= ~sync_s2[0];
      end
   end

   // settings only change while no frame is open,
   // so the link side reads them as stable values
   always_ff @(posedge clock) begin
      if (!rstn) begin
         cfg_lat <= `PSBW_LAT_RST;
         cfg_zl_mem <= 1'b0;
         cfg_zl_reg <= 1'b0;
         cfg_hybrid <= 1'b0;
         cfg_wlen <= `PSBW_WLEN_RST;
         strobe_level <= 1'b0;
      end else if (ce && sync_s2[0]) begin
         cfg_lat <= latency_count;
         cfg_zl_mem <= zero_lat_mem;
         cfg_zl_reg <= zero_lat_reg;
         cfg_hybrid <= hybrid_wrap;
         cfg_wlen <= wrap_len_log2;
         strobe_level <= extra_latency_req;
      end
   end

   // write word handed to the array side
   always_ff @(posedge clock) begin
      if (!rstn) begin
         wr_valid <= 1'b0;
         wr_addr <= '0;
         wr_data <= 16'h0000;
         wr_be <= 2'h0;
         wr_reg_space <= 1'b0;
      end else if (ce) begin
         wr_valid <= word_evt;
         if (word_evt) begin
            wr_addr <= hold_addr;
            wr_data <= hold_data;
            wr_be <= hold_be;
            wr_reg_space <= hold_reg;
         end
      end
   end

   // decoded transaction report
   always_ff @(posedge clock) begin
      if (!rstn) begin
         txn_valid <= 1'b0;
         txn_read <= 1'b0;
         txn_reg_space <= 1'b0;
         txn_linear <= 1'b0;
         txn_zero_lat <= 1'b0;
         txn_extra_lat <= 1'b0;
      end else if (ce) begin
         txn_valid <= txn_evt;
         if (txn_evt) begin
            txn_read <= hold_read;
            txn_reg_space <= hold_txn_reg;
            txn_linear <= hold_lin;
            txn_zero_lat <= hold_zl;
            txn_extra_lat <= hold_ext;
         end
      end
   end

   // one pulse per dropped word
   always_ff @(posedge clock) begin
      if (!rstn) begin
         burst_discard <= 1'b0;
      end else if (ce) begin
         burst_discard <= drop_evt;
      end
   end

   // ---- link domain ----

   // strobe is ours only during command cycles
   assign read_write_strobe_out = strobe_level;
   assign read_write_strobe_oe = ca_drive & ~cs_n;

   // first byte of each word on the rising edge
   always_ff @(posedge link_clk) begin
      dq_rise <= dq_in;
      strobe_rise <= read_write_strobe_in;
   end

   // decode of the command word as it completes
   assign ca_now = {ca_sr, dq_rise, dq_in};
   assign ca_done = (phase == PSBW_PH_CA) && (ca_cyc == `PSBW_CA_LAST_CYC);
   assign dec_write = ca_now[`PSBW_CA_RW_BIT] == `PSBW_CA_WRITE;
   assign dec_reg = ca_now[`PSBW_CA_SPACE_BIT] == `PSBW_CA_REG_SPACE;
   assign dec_lin = ca_now[`PSBW_CA_BURST_BIT] == `PSBW_CA_LINEAR;
   assign dec_zl = dec_reg ? cfg_zl_reg : cfg_zl_mem;
   // row bits and word-in-row bits form the word address
   assign ca_addr = {ca_now[`PSBW_CA_ROW_HI:`PSBW_CA_ROW_LO],
                     ca_now[`PSBW_CA_COL_HI:`PSBW_CA_COL_LO]};

   // latency: a zero setting is taken as one count
   assign lat_base = (cfg_lat == 4'h0) ? `PSBW_LAT_MIN : cfg_lat;
   assign lat_total = ext_seen ? {lat_base, 1'b0} : {1'b0, lat_base};

   // sequencer control
   assign burst.load = ca_done && dec_write;
   assign burst.step = (phase == PSBW_PH_DATA);
   assign burst.start_addr = ca_addr[AW-1:0];
   assign burst.len_log2 = cfg_wlen;
   // wrapped writes fall back to linear when unsupported
   assign burst.mode = (dec_lin || !WRAP_WRITES) ? PSBW_LINEAR :
                       (cfg_hybrid ? PSBW_HYBRID : PSBW_WRAP);

   // optional device limit on words per burst
   assign limit_hit = (MAX_BURST_WORDS != 0) && (word_cnt >= 16'(MAX_BURST_WORDS));
   assign accept = !burst.past_end && !limit_hit;

   // command, latency and data phases; cs_n high clears,
   // so nothing waits for a clock edge after the frame
   always_ff @(negedge link_clk or posedge cs_n) begin
      if (cs_n) begin
         phase <= PSBW_PH_CA;
         ca_cyc <= `PSBW_CA_FIRST_CYC;
         ca_sr <= 32'h0000_0000;
         ext_seen <= 1'b0;
         lat_left <= 5'h00;
         txn_zl <= 1'b0;
         txn_reg <= 1'b0;
         ca_drive <= 1'b1;
      end else begin
         unique case (phase)
            PSBW_PH_CA: begin
               ca_sr <= ca_now[31:0];
               ca_cyc <= ca_cyc + 2'h1;
               // our own strobe level, read back mid-command
               if (ca_cyc == `PSBW_CA_EXT_CYC) begin
                  ext_seen <= strobe_rise;
               end
               if (ca_done) begin
                  ca_drive <= 1'b0;
                  txn_reg <= dec_reg;
                  txn_zl <= dec_zl;
                  if (!dec_write) begin
                     phase <= PSBW_PH_READ;
                  end else if (dec_zl) begin
                     phase <= PSBW_PH_DATA;
                  end else if (lat_total == `PSBW_LAT_DONE) begin
                     phase <= PSBW_PH_DATA;
                  end else begin
                     phase <= PSBW_PH_LAT;
                     lat_left <= lat_total - `PSBW_LAT_DONE;
                  end
               end
            end
            PSBW_PH_LAT: begin
               if (lat_left == `PSBW_LAT_DONE) begin
                  phase <= PSBW_PH_DATA;
               end else begin
                  lat_left <= lat_left - `PSBW_LAT_DONE;
               end
            end
            PSBW_PH_DATA: begin
               phase <= PSBW_PH_DATA;
            end
            PSBW_PH_READ: begin
               phase <= PSBW_PH_READ;
            end
         endcase
      end
   end

   // words counted per frame for the burst limit
   always_ff @(negedge link_clk or posedge cs_n) begin
      if (cs_n) begin
         word_cnt <= 16'h0000;
      end else if (phase == PSBW_PH_DATA && word_cnt != 16'hFFFF) begin
         word_cnt <= word_cnt + 16'h0001;
      end
   end

   // hand-off registers survive the frame; the toggles
   // tell the system side a new value sits in them
   always_ff @(negedge link_clk or negedge rstn) begin
      if (!rstn) begin
         hold_read <= 1'b0;
         hold_txn_reg <= 1'b0;
         hold_lin <= 1'b0;
         hold_zl <= 1'b0;
         hold_ext <= 1'b0;
         tog_txn <= 1'b0;
      end else if (ca_done) begin
         hold_read <= !dec_write;
         hold_txn_reg <= dec_reg;
         hold_lin <= dec_lin;
         hold_zl <= dec_zl && dec_write;
         hold_ext <= ext_seen;
         tog_txn <= ~tog_txn;
      end
   end

   // one data word per falling edge in the data phase
   always_ff @(negedge link_clk or negedge rstn) begin
      if (!rstn) begin
         hold_addr <= '0;
         hold_data <= 16'h0000;
         hold_be <= 2'h0;
         hold_reg <= 1'b0;
         tog_word <= 1'b0;
         tog_drop <= 1'b0;
      end else if (phase == PSBW_PH_DATA && !cs_n) begin
         if (accept) begin
            hold_addr <= burst.addr;
            hold_data <= {dq_rise, dq_in};
            // mask high drops the byte; none in zero latency
            hold_be <= txn_zl ? `PSBW_NO_MASK :
                       ~{strobe_rise, read_write_strobe_in};
            hold_reg <= txn_reg;
            tog_word <= ~tog_word;
         end else begin
            tog_drop <= ~tog_drop;
         end
      end
   end
endmodule : psbw_write_path

// [rtl/psbw_map.svh]
// Purpose: named constants of the write path
// Assumes: included by bare name
// Notes: bit positions refer to the 48-bit command word
`ifndef PSBW_MAP_SVH
`define PSBW_MAP_SVH
`define PSBW_CA_RW_BIT 47
`define PSBW_CA_SPACE_BIT 46
`define PSBW_CA_BURST_BIT 45
`define PSBW_CA_ROW_HI 44
`define PSBW_CA_ROW_LO 16
`define PSBW_CA_COL_HI 2
`define PSBW_CA_COL_LO 0
`define PSBW_CA_WRITE 1'h0
`define PSBW_CA_REG_SPACE 1'h1
`define PSBW_CA_LINEAR 1'h1
`define PSBW_CA_FIRST_CYC 2'h0
`define PSBW_CA_EXT_CYC 2'h1
`define PSBW_CA_LAST_CYC 2'h2
`define PSBW_LAT_MIN 4'h1
`define PSBW_LAT_DONE 5'h01
`define PSBW_NO_MASK 2'h3
`define PSBW_SYNC_RST 4'h1
`define PSBW_LAT_RST 4'h4
`define PSBW_WLEN_RST 3'h3
`endif

// [rtl/psbw_pkg.sv]
// Purpose: shared types of the write path
// Assumes: nothing
// Notes: constants live in psbw_map.svh
package psbw_pkg;
   // link-side phase of one frame
   typedef enum logic [1:0] {PSBW_PH_CA, PSBW_PH_LAT, PSBW_PH_DATA, PSBW_PH_READ} psbw_phase_t;
   // address sequencing mode of a burst
   typedef enum logic [1:0] {PSBW_LINEAR, PSBW_WRAP, PSBW_HYBRID} psbw_burst_t;
endpackage : psbw_pkg

// [rtl/psbw_burst_if.sv]
// Purpose: carrier between frame logic and address sequencer
// Assumes: both ends on the link clock
// Notes: load and step are sampled on the falling edge
`timescale 1ns/1ps
interface psbw_burst_if #(parameter int AW = 22) ();
   logic load;
   logic step;
   logic [AW-1:0] start_addr;
   psbw_pkg::psbw_burst_t mode;
   logic [2:0] len_log2;
   logic [AW-1:0] addr;
   logic past_end;
   modport ctrl (output load, step, start_addr, mode, len_log2, input addr, past_end);
   modport seq (input load, step, start_addr, mode, len_log2, output addr, past_end);
endinterface : psbw_burst_if

// [rtl/psbw_addr_seq.sv]
// Purpose: word address sequencer for write bursts
// Assumes: link clock, cleared while chip select is high
// Notes: burst length is 2**len_log2 words
`timescale 1ns/1ps
module psbw_addr_seq #(
   parameter int AW = 22
) (
   input wire logic link_clk,
   input wire logic frame_rst,
   psbw_burst_if.seq bus
);
   import psbw_pkg::*;
   localparam logic [AW-1:0] ONE = AW'(1);
   logic [AW-1:0] len_words;
   logic [AW-1:0] wrap_mask;
   logic [AW-1:0] next_wrap;
   logic [AW:0] next_group;
   logic [AW-1:0] start;
   logic [AW-1:0] cnt;
   psbw_burst_t mode;
   // wrap arithmetic
   assign len_words = ONE << bus.len_log2;
   assign wrap_mask = len_words - ONE;
   assign next_wrap = (bus.addr & ~wrap_mask) | ((bus.addr + ONE) & wrap_mask);
   assign next_group = {1'b0, start & ~wrap_mask} + {1'b0, len_words};
   // advance one word per step
   always_ff @(negedge link_clk or posedge frame_rst) begin
      if (frame_rst) begin
         bus.addr <= '0;
         bus.past_end <= 1'b0;
         start <= '0;
         cnt <= '0;
         mode <= PSBW_LINEAR;
      end else if (bus.load) begin
         bus.addr <= bus.start_addr;
         bus.past_end <= 1'b0;
         start <= bus.start_addr;
         cnt <= '0;
         mode <= bus.mode;
      end else if (bus.step && !bus.past_end) begin
         unique case (mode)
            PSBW_LINEAR: begin
               // crosses pages freely; stops at array end
               if (&bus.addr) begin
                  bus.past_end <= 1'b1;
               end else begin
                  bus.addr <= bus.addr + ONE;
               end
            end
            PSBW_WRAP: begin
               bus.addr <= next_wrap;
            end
            PSBW_HYBRID: begin
               cnt <= cnt + ONE;
               // after one full wrap go linear from next boundary
               if (cnt == wrap_mask) begin
                  mode <= PSBW_LINEAR;
                  if (next_group[AW]) begin
                     bus.past_end <= 1'b1;
                  end else begin
                     bus.addr <= next_group[AW-1:0];
                  end
               end else begin
                  bus.addr <= next_wrap;
               end
            end
         endcase
      end
   end
endmodule : psbw_addr_seq

// [verif/psbw_write_path_checker.sv]
// Purpose: port-level checks of the write path
// Assumes: sampled on clock, rstn low clears
// Notes: bound to every write path instance
`timescale 1ns/1ps
module psbw_write_path_checker #(
   parameter int AW = 22
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic cs_n,
   input wire logic zero_lat_mem,
   input wire logic zero_lat_reg,
   input wire logic read_write_strobe_out,
   input wire logic read_write_strobe_oe,
   input wire logic extra_latency_req,
   input wire logic wr_valid,
   input wire logic [1:0] wr_be,
   input wire logic wr_reg_space,
   input wire logic txn_valid,
   input wire logic txn_read,
   input wire logic txn_reg_space,
   input wire logic txn_zero_lat,
   input wire logic burst_discard,
   input wire logic frame_active
);
   default clocking dc @(posedge clock); endclocking
   default disable iff (!rstn);
   // pulses and decode
   AST_WR_PULSE: assert property (wr_valid |=> !wr_valid)
      else $error("write pulse too long");
   AST_TXN_PULSE: assert property (txn_valid |=> !txn_valid)
      else $error("decode pulse too long");
   AST_DISC: assert property (burst_discard |-> !wr_valid ##1 !burst_discard)
      else $error("dropped word written");
   AST_ZL_FULL: assert property (wr_valid && txn_zero_lat |-> wr_be == 2'h3)
      else $error("zero latency word masked");
   AST_SPACE: assert property (wr_valid |-> wr_reg_space == txn_reg_space)
      else $error("write space differs from decode");
   AST_NO_READ: assert property (wr_valid |-> !txn_read)
      else $error("read frame wrote data");
   AST_OE_FRAME: assert property (read_write_strobe_oe |-> !cs_n)
      else $error("strobe driven outside frame");
   AST_OE_LEVEL: assert property (read_write_strobe_oe |-> read_write_strobe_out == extra_latency_req)
      else $error("strobe level differs from request");
   AST_OE_END: assert property ($fell(cs_n) |-> ##[1:100] !read_write_strobe_oe)
      else $error("strobe held past command");
   AST_OE_STEADY: assert property (read_write_strobe_oe && $past(read_write_strobe_oe)
      |-> $stable(read_write_strobe_out))
      else $error("strobe level moved in command");
   AST_FRAME_START: assert property ($fell(cs_n) |-> ##[1:6] frame_active)
      else $error("frame not seen");
   AST_ZL_DECODE: assert property (txn_valid && !txn_read
      |-> txn_zero_lat == (txn_reg_space ? zero_lat_reg : zero_lat_mem))
      else $error("zero latency decode wrong");
   // main scenarios reached
   cover property (wr_valid && wr_be != 2'h3);
   cover property (txn_valid && txn_zero_lat);
   cover property (burst_discard);
   cover property (txn_valid && txn_read);
endmodule : psbw_write_path_checker
bind psbw_write_path psbw_write_path_checker #(.AW(AW)) chk (
   .clock(clock), .rstn(rstn), .cs_n(cs_n), .zero_lat_mem(zero_lat_mem), .zero_lat_reg(zero_lat_reg),
   .read_write_strobe_out(read_write_strobe_out), .read_write_strobe_oe(read_write_strobe_oe),
   .extra_latency_req(extra_latency_req),
   .wr_valid(wr_valid), .wr_be(wr_be), .wr_reg_space(wr_reg_space), .txn_valid(txn_valid),
   .txn_read(txn_read), .txn_reg_space(txn_reg_space), .txn_zero_lat(txn_zero_lat),
   .burst_discard(burst_discard), .frame_active(frame_active)
);

// [verif/psbw_host_model.sv]
// Purpose: bus master driving frames into the write path
// Assumes: link clock 125 ns, stopped between frames
// Notes: released lines carry a moving pattern
`timescale 1ns/1ps
module psbw_host_model (
   output logic link_clk,
   output logic cs_n,
   output logic [7:0] dq_in,
   output logic strobe_wire,
   input wire logic read_write_strobe_out,
   input wire logic read_write_strobe_oe
);
   logic hoe = 1'b0;
   logic hval = 1'b0;
   logic rel = 1'b0;
   logic drive = 1'b0;
   logic at_rise = 1'b0;
   logic [7:0] hdq = 8'h00;
   initial begin
      link_clk = 1'b0;
      cs_n <= 1'b1; // late edge so the frame clear is seen
   end
   // pattern for undriven lines
   always @(link_clk) rel <= ~rel;
   assign strobe_wire = read_write_strobe_oe ? read_write_strobe_out : (hoe ? hval : rel);
   assign dq_in = drive ? hdq : {8{rel}};
   // one link cycle, bytes centred on both edges
   task automatic one_cycle(input logic [7:0] a, input logic [7:0] b, input logic [1:0] m, input logic oe);
      hoe = oe;
      hdq = a;
      hval = m[1];
      #31.25 link_clk = 1'b1;
      at_rise = strobe_wire;
      #31.25 hdq = b;
      hval = m[0];
      #31.25 link_clk = 1'b0;
      #31.25;
   endtask : one_cycle
   // whole frame: command, latency, data, close
   task automatic frame(input logic [47:0] cmd, input int idle, input bit zl, input int n,
         input logic [15:0] d[8], input logic [1:0] m[8], output logic ext);
      drive = 1'b1;
      cs_n = 1'b0;
      #62.5;
      for (int i = 0; i < 3; i++) begin
         one_cycle(cmd[47 - 16 * i -: 8], cmd[39 - 16 * i -: 8], 2'h0, 1'b0);
         if (i == 1) ext = at_rise;
      end
      for (int i = 0; i < idle; i++) one_cycle(~hdq, hdq, 2'h0, 1'b0);
      for (int i = 0; i < n; i++) one_cycle(d[i][15:8], d[i][7:0], m[i], !zl);
      #31.25 cs_n = 1'b1;
      hoe = 1'b0;
      drive = 1'b0;
      #250;
   endtask : frame
endmodule : psbw_host_model

// [verif/psbw_write_path_tb_top.sv]
// Purpose: self-checking bench of the write path
// Assumes: host model owns the link pins
// Notes: expected words queue up, a monitor pops them
`timescale 1ns/1ps
module psbw_write_path_tb_top;
   logic clock = 1'b0;
   logic rstn;
   logic ce = 1'b1;
   logic [3:0] latency_count = 4'h4;
   logic extra_latency_req = 1'b0;
   logic zero_lat_mem = 1'b0;
   logic zero_lat_reg = 1'b0;
   logic hybrid_wrap = 1'b0;
   logic [2:0] wrap_len_log2 = 3'h3;
   logic link_clk, cs_n, rws, rws_out, rws_oe, wr_valid, wr_reg_space, burst_discard, frame_active;
   logic txn_valid, txn_read, txn_reg_space, txn_linear, txn_zero_lat, txn_extra_lat;
   logic [7:0] dq_in;
   logic [21:0] wr_addr;
   logic [15:0] wr_data;
   logic [1:0] wr_be;
   logic [47:0] wq[$];
   logic [47:0] tq[$];
   logic [31:0] lfsr = 32'h0001_43f0;
   int err_total = 0;
   int check_count = 0;
   int cycles = 0;
   int disc = 0;
   int disc_exp = 0;
   always #2.5 clock = ~clock;
   psbw_write_path dut (
      .clock(clock), .rstn(rstn), .ce(ce), .link_clk(link_clk), .cs_n(cs_n), .dq_in(dq_in),
      .read_write_strobe_in(rws), .read_write_strobe_out(rws_out), .read_write_strobe_oe(rws_oe),
      .latency_count(latency_count), .extra_latency_req(extra_latency_req), .zero_lat_mem(zero_lat_mem),
      .zero_lat_reg(zero_lat_reg), .hybrid_wrap(hybrid_wrap), .wrap_len_log2(wrap_len_log2),
      .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data), .wr_be(wr_be), .wr_reg_space(wr_reg_space),
      .txn_valid(txn_valid), .txn_read(txn_read), .txn_reg_space(txn_reg_space), .txn_linear(txn_linear),
      .txn_zero_lat(txn_zero_lat), .txn_extra_lat(txn_extra_lat), .burst_discard(burst_discard),
      .frame_active(frame_active)
   );
   psbw_host_model host (
      .link_clk(link_clk), .cs_n(cs_n), .dq_in(dq_in), .strobe_wire(rws),
      .read_write_strobe_out(rws_out), .read_write_strobe_oe(rws_oe)
   );
   function automatic logic [31:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction : rnd
   task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
      check_count++;
      if (e !== g) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : summarize
   // configuration changes only between frames
   task automatic cfg(input logic [3:0] lat, input logic ex, input logic [1:0] zl, input logic hy,
         input logic [2:0] wl);
      @(posedge clock);
      latency_count <= lat;
      extra_latency_req <= ex;
      zero_lat_mem <= zl[0];
      zero_lat_reg <= zl[1];
      hybrid_wrap <= hy;
      wrap_len_log2 <= wl;
      repeat (4) @(posedge clock);
   endtask : cfg
   // one frame: note expectations, then let the host send it
   task automatic xfer(input bit rd, input bit rg, input int mode, input logic [21:0] a, input int n);
      logic [15:0] d[8];
      logic [1:0] m[8];
      logic [22:0] ad;
      logic [21:0] ln;
      logic seen;
      bit zl;
      int l;
      zl = !rd && (rg ? zero_lat_reg : zero_lat_mem);
      l = (latency_count == 4'h0) ? 1 : int'(latency_count);
      l = extra_latency_req ? 2 * l : l;
      ln = 22'h1 << wrap_len_log2;
      tq.push_back({43'h0, rd, rg, mode == 0, zl, extra_latency_req});
      for (int i = 0; i < n; i++) begin
         d[i] = 16'(rnd());
         m[i] = 2'(rnd());
         ad = {1'b0, a & ~(ln - 22'h1)} + ((mode == 2 && i >= ln) ? 23'(i)
            : {1'b0, (a + 22'(i)) & (ln - 22'h1)});
         if (mode == 0) ad = {1'b0, a} + 23'(i);
         if (ad[22]) disc_exp++;
         else wq.push_back({7'h00, rg, ad[21:0], d[i], zl ? 2'h3 : ~m[i]});
      end
      host.frame({rd, rg, mode == 0, 10'h000, a[21:3], 13'h0000, a[2:0]}, zl ? 0 : l - 1, zl, n, d, m, seen);
      chk("strobe_in_command", {47'h0, extra_latency_req}, {47'h0, seen});
      for (int w = 0; w < 80 && wq.size() + tq.size() > 0; w++) @(posedge clock);
      chk("pending", 48'h0, 48'(wq.size() + tq.size()));
   endtask : xfer
   // monitor takes the oldest note for each result
   always @(posedge clock) begin
      if (burst_discard === 1'b1) disc++;
      if (wr_valid === 1'b1) chk("word", wq.pop_front(), {7'h00, wr_reg_space, wr_addr, wr_data, wr_be});
      if (txn_valid === 1'b1) chk("decode", tq.pop_front(),
         {43'h0, txn_read, txn_reg_space, txn_linear, txn_zero_lat, txn_extra_lat});
   end
   // hang guard
   always @(posedge clock) begin
      cycles++;
      if (cycles == 60000) begin
         err_total++;
         summarize();
      end
   end
   initial begin
      rstn <= 1'b0; // real falling edge clears the link hand-off toggles
      repeat (3) @(posedge clock);
      rstn <= 1'b1;
      repeat (3) @(posedge clock);
      // spaces, latency kinds and burst modes in turn
      for (int k = 0; k < 16; k++) begin
         cfg(4'(rnd()), k[1], 2'(k >> 2), k % 3 == 2, 3'(1 + rnd() % 2));
         xfer(1'b0, k[0], k % 3, 22'(rnd()), 3 + int'(rnd() % 4));
      end
      // read command decoded, no data taken
      xfer(1'b1, 1'b0, 0, 22'(rnd()), 0);
      // linear burst running off the top of the array
      cfg(4'h0, 1'b0, 2'h0, 1'b0, 3'h3);
      xfer(1'b0, 1'b0, 0, 22'h3f_fffe, 4);
      chk("discards", 48'(disc_exp), 48'(disc));
      summarize();
   end
endmodule : psbw_write_path_tb_top
